// *** design/clhi_params.svh ***
// Constants for the character LCD host interface.
// Function
// RL1: Parallel status read returns busy flag on bit 7, pointer below.
// RL2: Host waits for busy flag low before the next instruction.
// RL3: Data write stores into display or glyph memory per last address set.
// RL4: After a data write the pointer steps by one.
// RL5: Parallel data read returns a byte from the selected memory.
// RL6: First read without prior address set is invalid; later reads good.
// RL7: Cursor shift loads the read latch like a display address set.
// RL8: After a data read the pointer steps by one.
// RL9: Read after write without address set returns the old latch.
// RL10: Host waits half an oscillator period after busy falls.
// RL11: 4-bit mode uses lines 7..4, high nibble first.
// RL12: 4-bit mode raises busy only after the second nibble.
// RL13: 8-bit mode moves a byte in one transfer.
// RL14: Two straps select parallel, I2C or SPI port.
// RL15: SPI uses line 5 select, line 6 clock, line 7 data.
// RL16: SPI clock idles high, data sampled on rising edge.
// RL17: I2C uses line 6 data, line 7 clock, line 5 tied low.
// RL18: Host sets bus width bit to one in I2C mode.
// RL19: I2C master starts only on an idle bus.
// RL20: SDA fall with SCL high is START, rise is STOP.
// RL21: Addressed slave pulls SDA low through the ninth clock high.
// RL22: I2C carries instructions and RAM data.
// RL23: Four slave addresses, low two bits from straps on lines 0, 1.
// RL24: Control byte holds chain flag and payload kind bit.
// RL25: Step direction one increments pointer, zero decrements.
// RL26: Register select routes bytes to instruction or data latch.
// RL27: Busy flag stays high from acceptance until operation completes.
`ifndef CLHI_PARAMS_SVH
`define CLHI_PARAMS_SVH
`define CLHI_FIFO_DEPTH  16
`define CLHI_FIFO_WIDTH  9
`define CLHI_I2C_ADDR_HI 5'h0F
`define CLHI_RST_WIDTH8  1'b1
`define CLHI_RST_INCR    1'b1
`define CLHI_STRAP_WAIT  2'h2
`define CLHI_POS_CHAIN   7
`define CLHI_POS_KIND    6
`define CLHI_POS_DL      4
`define CLHI_POS_ID      1
`define CLHI_POS_RL      2
`define CLHI_POS_E       10
`define CLHI_POS_RS      9
`define CLHI_POS_RW      8
`define CLHI_POS_CS      5
`define CLHI_POS_SCK     6
`define CLHI_POS_SDI     7
`define CLHI_POS_SDA     6
`define CLHI_POS_SCL     7
`endif

// *** design/clhi_pkg.sv ***
// Types shared by the character LCD host interface.
package clhi_pkg;
    typedef enum logic [2:0] {
        CLHI_MODE_PAR = 3'b001,
        CLHI_MODE_I2C = 3'b010,
        CLHI_MODE_SPI = 3'b100
    } clhi_mode_e;
    typedef enum logic [4:0] {
        CLHI_I_IDLE = 5'b00001,
        CLHI_I_ADDR = 5'b00010,
        CLHI_I_CTRL = 5'b00100,
        CLHI_I_DATA = 5'b01000,
        CLHI_I_SKIP = 5'b10000
    } clhi_i2c_e;
    typedef logic [7:0] clhi_byte_t;
endpackage

// *** design/clhi_host_if.sv ***
// FIFO and host port logic of the character LCD host interface.
`timescale 1ns/100ps
`default_nettype none
`include "clhi_params.svh"

module clhi_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_i,       // System clock.
    input  wire logic             rst_i,       // Async reset, high.
    input  wire logic             in_valid_i,  // Write request.
    output logic                  in_ready_o,  // Space available.
    input  wire logic [WIDTH-1:0] in_data_i,   // Write word.
    output logic                  out_valid_o, // Word available.
    input  wire logic             out_ready_i, // Read request.
    output logic      [WIDTH-1:0] out_data_o   // Head word.
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_r;
    logic [AW:0]      rd_r;
    wire              full_w  = (wr_r[AW] != rd_r[AW]) &&
                                (wr_r[AW-1:0] == rd_r[AW-1:0]);
    wire              empty_w = (wr_r == rd_r);
    wire              wr_w    = in_valid_i && !full_w;
    wire              rd_w    = out_ready_i && !empty_w;

    assign in_ready_o  = !full_w;
    assign out_valid_o = !empty_w;
    assign out_data_o  = mem[rd_r[AW-1:0]];

    always_ff @(posedge clk_i) begin
        if (wr_w) begin
            mem[wr_r[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_r <= '0;
            rd_r <= '0;
        end else begin
            wr_r <= wr_w ? wr_r + 1'b1 : wr_r;
            rd_r <= rd_w ? rd_r + 1'b1 : rd_r;
        end
    end
endmodule

module clhi_host_if
    import clhi_pkg::*;
(
    input  wire logic       sys_clk_i,          // 250 MHz clock.
    input  wire logic       rst_i,              // Async reset, high.
    input  wire logic       port_strap_high_i,  // Port strap, high bit.
    input  wire logic       port_strap_low_i,   // Port strap, low bit.
    input  wire logic       e_i,                // Parallel enable strobe.
    input  wire logic       register_select_i,  // 0 instruction, 1 data.
    input  wire logic       rw_i,               // 1 read, 0 write.
    input  wire logic [7:0] db_i,               // Data lines in.
    output logic      [7:0] db_o,               // Data lines out.
    output logic      [7:0] db_oe_o,            // Data line drive enable.
    output logic            cmd_valid_o,        // Byte for core ready.
    output logic            cmd_is_data_o,      // 1 data, 0 instruction.
    output logic      [7:0] cmd_byte_o,         // Byte for core.
    input  wire logic       cmd_ready_i,        // Core takes the byte.
    input  wire logic       op_done_i,          // Core finished one op.
    output logic            fetch_o,            // Read latch refill.
    output logic            glyph_sel_o,        // 1 glyph, 0 display.
    input  wire logic [7:0] fetch_data_i,       // Memory read data.
    input  wire logic       fetch_valid_i,      // Read data valid.
    output logic            internal_op_flag_o, // Busy flag.
    output logic      [6:0] address_pointer_o,  // Address pointer.
    output logic            bus_width_bit_o     // 1 eight-bit bus.
);
    // ------------------------------------------------------------------
    // Pin synchronisers and strap capture
    // ------------------------------------------------------------------
    logic [12:0] s1_r, s2_r, s3_r;
    logic [1:0]  strap_cnt_r;
    logic [1:0]  sa_r;
    clhi_mode_e  mode_r;
    clhi_i2c_e   ist_r;

    wire [12:0] pins_w = {port_strap_high_i, port_strap_low_i, e_i,
                          register_select_i, rw_i, db_i};
    wire e_rise = s2_r[`CLHI_POS_E] && !s3_r[`CLHI_POS_E];
    wire e_fall = !s2_r[`CLHI_POS_E] && s3_r[`CLHI_POS_E];
    wire rs_d   = s3_r[`CLHI_POS_RS];
    wire rw_d   = s3_r[`CLHI_POS_RW];
    wire m_par  = (mode_r == CLHI_MODE_PAR);
    wire m_i2c  = (mode_r == CLHI_MODE_I2C);
    wire m_spi  = (mode_r == CLHI_MODE_SPI);

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= pins_w;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Straps are only trusted once the synchroniser has filled.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            strap_cnt_r <= '0;
            mode_r      <= CLHI_MODE_PAR;
            sa_r        <= '0;
        end else if (strap_cnt_r < `CLHI_STRAP_WAIT) begin
            strap_cnt_r <= strap_cnt_r + 2'h1;
        end else if (strap_cnt_r == `CLHI_STRAP_WAIT) begin
            strap_cnt_r <= strap_cnt_r + 2'h1;
            case (s2_r[12:11]) // RL14
                2'b01:   mode_r <= CLHI_MODE_I2C;
                2'b10:   mode_r <= CLHI_MODE_SPI;
                default: mode_r <= CLHI_MODE_PAR;
            endcase
            sa_r <= s2_r[1:0]; // RL23
        end
    end

    // ------------------------------------------------------------------
    // Serial bit level (SPI and I2C share the shifter)
    // ------------------------------------------------------------------
    logic [7:0] sh_r;
    logic [3:0] cnt_r;
    logic       chain_r, kind_r, ack_r, nib_r, width8_r;
    logic [3:0] hi_r;
    wire  in_ready;

    wire spi_cs_n = s2_r[`CLHI_POS_CS]; // RL15
    wire spi_rise = s2_r[`CLHI_POS_SCK] && !s3_r[`CLHI_POS_SCK]; // RL16
    wire spi_bit  = s2_r[`CLHI_POS_SDI];
    wire scl      = s2_r[`CLHI_POS_SCL]; // RL17
    wire sda      = s2_r[`CLHI_POS_SDA];
    wire scl_rise = scl && !s3_r[`CLHI_POS_SCL];
    wire scl_fall = !scl && s3_r[`CLHI_POS_SCL];
    wire i_start  = m_i2c && scl && s3_r[`CLHI_POS_SCL] &&
                    s3_r[`CLHI_POS_SDA] && !sda; // RL20
    wire i_stop   = m_i2c && scl && s3_r[`CLHI_POS_SCL] &&
                    !s3_r[`CLHI_POS_SDA] && sda; // RL20
    wire i_live   = (ist_r == CLHI_I_ADDR) || (ist_r == CLHI_I_CTRL) ||
                    (ist_r == CLHI_I_DATA);
    wire i_byte   = m_i2c && i_live && scl_fall && (cnt_r == 4'h8);
    wire i_addr_ok = (sh_r[7:3] == `CLHI_I2C_ADDR_HI) &&
                     (sh_r[2:1] == sa_r) && !sh_r[0]; // RL23
    wire spi_push = m_spi && !spi_cs_n && spi_rise && (cnt_r == 4'h7);
    wire i2c_push = i_byte && (ist_r == CLHI_I_DATA) && in_ready; // RL22

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sh_r    <= '0;
            cnt_r   <= '0;
            ist_r   <= CLHI_I_IDLE;
            chain_r <= 1'b0;
            kind_r  <= 1'b0;
            ack_r   <= 1'b0;
        end else if (m_spi) begin
            if (spi_cs_n) begin
                cnt_r <= '0;
            end else if (spi_rise) begin
                sh_r  <= {sh_r[6:0], spi_bit};
                cnt_r <= (cnt_r == 4'h7) ? 4'h0 : cnt_r + 4'h1;
            end
        end else if (i_start) begin
            ist_r <= CLHI_I_ADDR;
            cnt_r <= '0;
            ack_r <= 1'b0;
        end else if (i_stop) begin
            ist_r <= CLHI_I_IDLE;
            ack_r <= 1'b0;
        end else if (m_i2c && i_live) begin
            if (scl_rise && cnt_r < 4'h8) begin
                sh_r  <= {sh_r[6:0], sda};
                cnt_r <= cnt_r + 4'h1;
            end else if (i_byte) begin
                cnt_r <= 4'h9;
                case (ist_r)
                    CLHI_I_ADDR: begin
                        ack_r <= i_addr_ok; // RL21
                        ist_r <= i_addr_ok ? CLHI_I_CTRL : CLHI_I_SKIP;
                    end
                    CLHI_I_CTRL: begin
                        ack_r   <= 1'b1; // RL21
                        chain_r <= sh_r[`CLHI_POS_CHAIN]; // RL24
                        kind_r  <= sh_r[`CLHI_POS_KIND]; // RL24
                        ist_r   <= CLHI_I_DATA;
                    end
                    CLHI_I_DATA: begin
                        // A full queue is refused by withholding the ack.
                        ack_r <= in_ready;
                        if (!in_ready) begin
                            ist_r <= CLHI_I_SKIP;
                        end else if (chain_r) begin
                            ist_r <= CLHI_I_CTRL; // RL24
                        end
                    end
                    default: ist_r <= CLHI_I_SKIP;
                endcase
            end else if (scl_fall && cnt_r == 4'h9) begin
                ack_r <= 1'b0;
                cnt_r <= '0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Parallel strobes and byte assembly
    // ------------------------------------------------------------------
    wire par_fall  = m_par && e_fall;
    wire par_last  = width8_r || nib_r; // RL12
    wire [7:0] par_byte = width8_r ? s3_r[7:0]
                                   : {hi_r, s3_r[7:4]}; // RL11 RL13
    wire par_push  = par_fall && !rw_d && par_last;
    wire read_done = par_fall && rw_d && rs_d && par_last; // RL8

    wire       push_req  = par_push || spi_push || i2c_push;
    wire       push_kind = m_i2c ? kind_r
                         : (m_spi ? s2_r[`CLHI_POS_RS] : rs_d); // RL26
    wire [7:0] push_byte = m_par ? par_byte : sh_r;
    wire [7:0] spi_byte  = {sh_r[6:0], spi_bit};
    wire [7:0] new_byte  = m_spi ? spi_byte : push_byte;
    wire       push      = push_req && in_ready;

    // ------------------------------------------------------------------
    // Instruction tracking, address pointer and read latch
    // ------------------------------------------------------------------
    logic [6:0] ptr_r;
    logic       incr_r, glyph_r, busy_r, fetch_r;
    logic [7:0] dout_r;
    wire  b_ins   = push && !push_kind;
    wire  b_dat   = push && push_kind;
    wire  is_dd   = new_byte[7];
    wire  is_cg   = (new_byte[7:6] == 2'b01);
    wire  is_fset = (new_byte[7:5] == 3'b001);
    wire  is_sh   = (new_byte[7:4] == 4'h1) && !new_byte[3];
    wire  is_ent  = (new_byte[7:2] == 6'h01);
    wire  is_home = (new_byte[7:2] == 6'h00) && (new_byte[1:0] != 2'b00);
    wire  is_clr  = (new_byte == 8'h01);
    wire [6:0] ptr_step = incr_r ? ptr_r + 7'h01 : ptr_r - 7'h01; // RL25
    wire [6:0] ptr_rl   = new_byte[`CLHI_POS_RL] ? ptr_r + 7'h01
                                                 : ptr_r - 7'h01;
    wire  load_latch = b_ins && (is_dd || is_cg || is_sh); // RL6 RL7
    wire  busy_view  = busy_r || !in_ready;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ptr_r    <= '0;
            incr_r   <= `CLHI_RST_INCR;
            glyph_r  <= 1'b0;
            width8_r <= `CLHI_RST_WIDTH8;
        end else if (b_ins) begin
            if (is_dd) begin
                ptr_r   <= new_byte[6:0];
                glyph_r <= 1'b0; // RL3
            end else if (is_cg) begin
                ptr_r   <= {1'b0, new_byte[5:0]};
                glyph_r <= 1'b1; // RL3
            end else if (is_fset) begin
                width8_r <= new_byte[`CLHI_POS_DL];
            end else if (is_sh) begin
                ptr_r <= ptr_rl;
            end else if (is_ent) begin
                incr_r <= new_byte[`CLHI_POS_ID];
            end else if (is_home) begin
                ptr_r   <= '0;
                glyph_r <= 1'b0;
                incr_r  <= is_clr ? 1'b1 : incr_r;
            end
        end else if (b_dat || read_done) begin
            ptr_r <= ptr_step; // RL4 RL8
        end
    end

    // A data write only steps the pointer, so the latch keeps old data.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            fetch_r <= 1'b0;
            dout_r  <= '0;
        end else begin
            fetch_r <= load_latch || read_done; // RL9
            dout_r  <= fetch_valid_i ? fetch_data_i : dout_r;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy_r <= 1'b0;
        end else begin
            busy_r <= push || (busy_r && !op_done_i); // RL27
        end
    end

    // ------------------------------------------------------------------
    // Parallel read drive and I2C acknowledge drive
    // ------------------------------------------------------------------
    wire [7:0] rd_val  = rs_d ? dout_r : {busy_view, ptr_r}; // RL1 RL5
    wire [7:0] rd_now  = s2_r[`CLHI_POS_RS] ? dout_r : {busy_view, ptr_r};
    wire [7:0] rd_nib  = nib_r ? {rd_now[3:0], 4'h0}
                               : {rd_now[7:4], 4'h0}; // RL11
    wire       rd_go   = m_par && e_rise && s2_r[`CLHI_POS_RW];
    wire [7:0] oe_mask = width8_r ? 8'hFF : 8'hF0;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            nib_r   <= 1'b0;
            hi_r    <= '0;
            db_o    <= '0;
            db_oe_o <= '0;
        end else begin
            if (width8_r) begin
                nib_r <= 1'b0;
            end else if (par_fall) begin
                nib_r <= !nib_r;
                hi_r  <= nib_r ? hi_r : s3_r[7:4];
            end
            if (m_i2c) begin
                db_o    <= '0;
                db_oe_o <= {1'b0, ack_r, 6'h00}; // RL21
            end else if (rd_go) begin
                db_o    <= width8_r ? rd_now : rd_nib;
                db_oe_o <= oe_mask;
            end else if (par_fall || !m_par) begin
                db_oe_o <= '0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Queue towards the core
    // ------------------------------------------------------------------
    wire       q_valid;
    wire [8:0] q_data;
    wire       q_take = q_valid && (!cmd_valid_o || cmd_ready_i);

    clhi_fifo #(
        .WIDTH (`CLHI_FIFO_WIDTH),
        .DEPTH (`CLHI_FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (sys_clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (push_req),
        .in_ready_o  (in_ready),
        .in_data_i   ({push_kind, new_byte}),
        .out_valid_o (q_valid),
        .out_ready_i (q_take),
        .out_data_o  (q_data)
    );

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cmd_valid_o   <= 1'b0;
            cmd_is_data_o <= 1'b0;
            cmd_byte_o    <= '0;
        end else if (!cmd_valid_o || cmd_ready_i) begin
            cmd_valid_o   <= q_valid;
            cmd_is_data_o <= q_data[8];
            cmd_byte_o    <= q_data[7:0];
        end
    end

    assign fetch_o            = fetch_r;
    assign glyph_sel_o        = glyph_r;
    assign internal_op_flag_o = busy_r;
    assign address_pointer_o  = ptr_r;
    assign bus_width_bit_o    = width8_r;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_dat_up;
        b_dat && incr_r;
    endsequence
    sequence s_ack_slot;
        i_byte && ist_r == CLHI_I_CTRL;
    endsequence

    property p_stat_read;
        rd_go && width8_r && !s2_r[`CLHI_POS_RS]
            |=> db_oe_o == 8'hFF && db_o == {$past(busy_view), $past(ptr_r)};
    endproperty
    a_stat_read: assert property (p_stat_read) // RL1
        else $error("status read value wrong");
    property p_busy;
        push |=> internal_op_flag_o;
    endproperty
    a_busy: assert property (p_busy) // RL27
        else $error("busy flag not raised");
    property p_step_up;
        s_dat_up |=> address_pointer_o == $past(ptr_r) + 7'h01;
    endproperty
    a_step_up: assert property (p_step_up) // RL4
        else $error("pointer did not step up");
    property p_step_dn;
        ((b_dat || read_done) && !incr_r)
            |=> address_pointer_o == $past(ptr_r) - 7'h01;
    endproperty
    a_step_dn: assert property (p_step_dn) // RL25
        else $error("pointer did not step down");
    property p_nibble;
        (par_fall && !rw_d && !width8_r && !nib_r) |-> !push;
    endproperty
    a_nibble: assert property (p_nibble) // RL12
        else $error("push on first nibble");
    property p_ack;
        s_ack_slot |=> ##1 db_oe_o[6] && !db_o[6];
    endproperty
    a_ack: assert property (p_ack) // RL21
        else $error("no acknowledge drive");
    property p_wr_nofetch;
        b_dat |=> !fetch_o;
    endproperty
    a_wr_nofetch: assert property (p_wr_nofetch) // RL9
        else $error("write refilled read latch");
    property p_shift_fetch;
        (b_ins && is_sh) |=> fetch_o;
    endproperty
    a_shift_fetch: assert property (p_shift_fetch) // RL7
        else $error("cursor shift did not refill");
    property p_start;
        i_start |=> ist_r == CLHI_I_ADDR && cnt_r == 4'h0;
    endproperty
    a_start: assert property (p_start) // RL20
        else $error("start not taken");
endmodule
`default_nettype wire

// *** testbench/clhi_host_model.sv ***
// Host microcontroller model driving the parallel and serial pins.
`timescale 1ns/100ps
`default_nettype none
module clhi_host_model (
    input  wire logic       clk_i, // System clock.
    input  wire logic [7:0] bus_i, // Resolved data lines.
    output var logic        e_o,   // Enable strobe.
    output var logic        rs_o,  // Register select.
    output var logic        rw_o,  // 1 read.
    output var logic  [7:0] db_o   // Host data drive.
);
    initial begin
        e_o = 0; rs_o = 0; rw_o = 0; db_o = 8'hFF;
    end
    // Released lines show an inverted pattern so stale data never matches.
    task automatic strobe(input logic r, w, input logic [7:0] d,
                          output logic [7:0] v);
        @(negedge clk_i);
        rs_o = r; rw_o = w; db_o = w ? ~db_o : d; e_o = 1;
        repeat (6) @(negedge clk_i);
        v = bus_i; e_o = 0;
        repeat (6) @(negedge clk_i);
        if (w) db_o = ~db_o;
    endtask
    task automatic xfer(input logic r, w, wide, input logic [7:0] d,
                        output logic [7:0] v);
        logic [7:0] h, l;
        if (wide) strobe(r, w, d, v);
        else begin
            strobe(r, w, {d[7:4], 4'h0}, h);
            strobe(r, w, {d[3:0], 4'h0}, l);
            v = {h[7:4], l[7:4]};
        end
    endtask
    task automatic spi(input logic r, input logic [7:0] d);
        // Park select and clock high first so no stray rising edge counts.
        @(negedge clk_i);
        db_o[6] = 1; db_o[5] = 1; rs_o = r;
        repeat (8) @(negedge clk_i);
        db_o[5] = 0;
        for (int i = 7; i >= 0; i--) begin
            repeat (8) @(negedge clk_i);
            db_o[6] = 0; db_o[7] = d[i];
            repeat (8) @(negedge clk_i);
            db_o[6] = 1;
        end
        repeat (8) @(negedge clk_i);
        db_o[5] = 1;
    endtask
    // One clock pulse; data only moves while the clock is low.
    task automatic i2c_bit(input logic b, output logic s);
        db_o[6] = b;
        repeat (8) @(negedge clk_i);
        db_o[7] = 1;
        repeat (4) @(negedge clk_i);
        s = bus_i[6];
        repeat (4) @(negedge clk_i);
        db_o[7] = 0;
        repeat (8) @(negedge clk_i);
    endtask
    task automatic i2c(input logic [7:0] c, d, input logic [1:0] sa,
                       output logic [2:0] ak);
        logic [23:0] s;
        logic        b;
        s = {5'h0F, sa, 1'b0, c, d};
        @(negedge clk_i);
        db_o[7:5] = 3'b110;
        repeat (8) @(negedge clk_i);
        db_o[6] = 0;
        repeat (8) @(negedge clk_i);
        db_o[7] = 0;
        repeat (8) @(negedge clk_i);
        for (int k = 23; k >= 0; k--) begin
            i2c_bit(s[k], b);
            if (k % 8 == 0) begin
                i2c_bit(1'b1, b);
                ak[k/8] = !b;
            end
        end
        db_o[6] = 0;
        repeat (8) @(negedge clk_i);
        db_o[7] = 1;
        repeat (8) @(negedge clk_i);
        db_o[6] = 1;
        repeat (8) @(negedge clk_i);
    endtask
endmodule
`default_nettype wire

// *** testbench/char_lcd_host_interface_bench.sv ***
// Self-checking bench for the character LCD host interface.
`timescale 1ns/100ps
`default_nettype none
module char_lcd_host_interface_bench;
    import clhi_pkg::*;
    logic       sys_clk_i, rst_i, sh, sl, e, rs, rw, rdy, done, fv;
    logic       hold, took, wide, cval, cdat, fetch, gsel, busy, bw;
    logic [7:0] hdb, bus, ddb, doe, cbyte, fd, q, d;
    logic [6:0] ap, ptr;
    logic [2:0] ak;
    int         failures, check_count;
    logic [8:0] exp_q[$];
    assign bus = (doe & ddb) | (~doe & hdb);
    clhi_host_if u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .port_strap_high_i(sh), .port_strap_low_i(sl), .e_i(e),
        .register_select_i(rs), .rw_i(rw), .db_i(bus), .db_o(ddb),
        .db_oe_o(doe), .cmd_valid_o(cval), .cmd_is_data_o(cdat),
        .cmd_byte_o(cbyte), .cmd_ready_i(rdy), .op_done_i(done),
        .fetch_o(fetch), .glyph_sel_o(gsel), .fetch_data_i(fd),
        .fetch_valid_i(fv), .internal_op_flag_o(busy),
        .address_pointer_o(ap), .bus_width_bit_o(bw));
    clhi_host_model u_host (.clk_i(sys_clk_i), .bus_i(bus), .e_o(e),
        .rs_o(rs), .rw_o(rw), .db_o(hdb));
    initial begin
        sys_clk_i = 0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end
    function automatic logic [7:0] mem(input logic [6:0] a);
        return {1'b1, a} ^ 8'h3C;
    endfunction
    task automatic check(input logic [7:0] got, exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cap();
        check({1'b0, ap}, {1'b0, ptr});
    endtask
    // Bounded status polling plus a settling gap before each request.
    task automatic poll();
        int n;
        n = 0; q = 8'h80;
        while (q[7] !== 1'b0 && n < 40) begin
            u_host.xfer(0, 1, wide, 8'h00, q);
            n++;
        end
        check({7'h0, q[7]}, 8'h00);
        repeat (4) @(negedge sys_clk_i);
    endtask
    task automatic wr(input logic r, input logic [7:0] v);
        poll();
        exp_q.push_back({r, v});
        u_host.xfer(r, 0, wide, v, q);
    endtask
    task automatic rd(output logic [7:0] v);
        poll();
        u_host.xfer(1, 1, wide, 8'h00, v);
    endtask
    task automatic rst_seq(input logic h, l);
        rst_i = 1; sh = h; sl = l; wide = 1;
        repeat (5) @(negedge sys_clk_i);
        rst_i = 0;
        repeat (8) @(negedge sys_clk_i);
    endtask
    task automatic finish_test();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Core side: random stalls, completion pulses, read latch refill.
    // ------------------------------------------------------------
    always @(posedge sys_clk_i) begin
        took <= cval & rdy;
        if (!rst_i && cval && rdy) begin
            check({7'h0, cdat}, {7'h0, exp_q[0][8]});
            check(cbyte, exp_q[0][7:0]);
            void'(exp_q.pop_front());
        end
    end
    always @(negedge sys_clk_i) begin
        done <= took;
        rdy <= hold ? 1'b0 : 1'($urandom % 2);
        fv <= fetch;
        fd <= mem(ap);
    end
    initial begin
        #400000;
        failures++;
        finish_test();
    end
    // ------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------
    initial begin
        void'($urandom(14303));
        {rst_i, sh, sl, rdy, done, fv, hold, took} = 8'h80;
        fd = 8'h00;
        rst_seq(0, 0);
        ptr = 7'h10 + 7'($urandom % 32);
        wr(0, {1'b1, ptr}); cap();
        rd(q); check(q, mem(ptr));
        ptr++; cap();
        wr(1, 8'($urandom)); ptr++; cap();
        rd(q); check(q, mem(ptr - 7'h1));
        ptr++;
        hold = 1;
        wr(1, 8'($urandom)); ptr++;
        u_host.xfer(0, 1, 1, 8'h00, q);
        check(q, {1'b1, ptr});
        hold = 0;
        wr(0, 8'h04); wr(1, 8'($urandom)); ptr--; cap();
        wr(0, 8'h06); wr(0, 8'h10); ptr--;
        rd(q); check(q, mem(ptr));
        ptr++; cap();
        d = 8'($urandom % 64); ptr = d[6:0];
        wr(0, 8'h40 | d); check({7'h0, gsel}, 8'h01);
        wr(1, 8'($urandom)); ptr++; cap();
        wr(0, 8'h20); wide = 0; check({7'h0, bw}, 8'h00);
        wr(1, 8'($urandom)); ptr++;
        poll(); cap();
        wr(0, 8'h30); wide = 1; check({7'h0, bw}, 8'h01);
        poll();
        rst_seq(1, 0);
        for (int i = 0; i < 4; i++) begin
            d = 8'($urandom);
            exp_q.push_back({d[0], d});
            u_host.spi(d[0], d);
            repeat (40) @(negedge sys_clk_i);
        end
        repeat (50) @(negedge sys_clk_i);
        check(8'(exp_q.size()), 8'h00);
        d = 8'($urandom);
        u_host.db_o = {6'b110000, d[1:0]};
        rst_seq(0, 1);
        check({7'h0, bw}, 8'h01);
        exp_q.push_back({d[2], d});
        u_host.i2c({1'b0, d[2], 6'h00}, d, d[1:0], ak);
        check(8'(ak), 8'h07);
        u_host.i2c(8'h40, d, ~d[1:0], ak);
        check(8'(ak), 8'h00);
        repeat (50) @(negedge sys_clk_i);
        check(8'(exp_q.size()), 8'h00);
        finish_test();
    end
endmodule
`default_nettype wire
